// ==== hw/texture_gather_gradient_decode.sv ====
// texture fetch decoder for gathers, gradient queries and detail-level queries
`timescale 1ns/1ps
`default_nettype none
`include "texture_gather_map.svh"

module texture_gather_gradient_decode #(
  parameter int GPR_BITS = 7,
  parameter int RES_BITS = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // instruction side
  input  wire logic                inst_valid_i,
  output logic                     inst_ready_o,
  input  wire logic [31:0]         inst_word0_i,
  input  wire logic [31:0]         inst_word1_i,
  input  wire logic [31:0]         inst_word2_i,
  input  wire logic [31:0]         inst_word3_i,
  input  wire logic [127:0]        src_data_i,
  input  wire logic [1:0]          res_format_i,
  input  wire logic [2:0]          cmp_func_i,
  // stored texel offsets
  input  wire logic                offsets_load_i,
  input  wire logic [14:0]         offsets_i,
  // sampler side
  output logic                     samp_req_valid_o,
  input  wire logic                samp_req_ready_i,
  output logic [2:0]               samp_req_kind_o,
  output logic [127:0]             samp_coord_o,
  output logic [14:0]              samp_offsets_o,
  output logic [RES_BITS-1:0]      samp_resource_o,
  input  wire logic                samp_resp_valid_i,
  input  wire logic [127:0]        samp_resp_data_i,
  // result side
  output logic                     result_valid_o,
  output logic [GPR_BITS-1:0]      result_gpr_o,
  output logic [127:0]             result_data_o,
  output logic                     illegal_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                legal;
    logic                                compare;
    logic                                stored;
    texture_gather_pkg::sampler_kind_type kind;
  } decode_type;

  function automatic decode_type decode_op(input logic [4:0] op);
    decode_type d;
    d = '{legal: 1'b1, compare: 1'b0, stored: 1'b0, kind: texture_gather_pkg::kind_gather};
    case (op)
      `OPC_GATHER: begin
        d.kind = texture_gather_pkg::kind_gather;
      end
      `OPC_GATHER_CMP: begin
        d.compare = 1'b1;
      end
      `OPC_GATHER_CMP_STORE: begin
        d.compare = 1'b1;
        d.stored  = 1'b1;
      end
      `OPC_GATHER_STORED: begin
        d.stored = 1'b1;
      end
      `OPC_GRAD_H: begin
        d.kind = texture_gather_pkg::kind_grad_h;
      end
      `OPC_GRAD_V: begin
        d.kind = texture_gather_pkg::kind_grad_v;
      end
      `OPC_DETAIL_LEVEL: begin
        d.kind = texture_gather_pkg::kind_detail_level;
      end
      `OPC_SAMPLE_COUNT: begin
        d.kind = texture_gather_pkg::kind_sample_count;
      end
      default: begin
        d.legal = 1'b0;
      end
    endcase
    return d;
  endfunction

  // word 3 carries only padding and is never looked at
  decode_type dec;
  logic       inst_take;
  logic       unused_pad;

  assign dec        = decode_op(inst_word0_i[`FLD_OPCODE_MSB:`FLD_OPCODE_LSB]);
  assign inst_take  = inst_valid_i && inst_ready_o;
  assign unused_pad = ^inst_word3_i;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  texture_gather_pkg::state_type state_reg;
  logic                          compare_reg;
  logic [31:0]                   ref_reg;
  logic [1:0]                    fmt_reg;
  logic [2:0]                    func_reg;
  logic [14:0]                   stored_offsets_reg;
  logic [127:0]                  resp_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= texture_gather_pkg::st_idle;
    end else begin
      case (state_reg)
        texture_gather_pkg::st_idle: begin
          if (inst_take && dec.legal) begin
            state_reg <= texture_gather_pkg::st_request;
          end
        end
        texture_gather_pkg::st_request: begin
          if (samp_req_ready_i) begin
            state_reg <= texture_gather_pkg::st_wait;
          end
        end
        texture_gather_pkg::st_wait: begin
          if (samp_resp_valid_i) begin
            state_reg <= texture_gather_pkg::st_result;
          end
        end
        default: begin
          state_reg <= texture_gather_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      inst_ready_o <= 1'b0;
    end else begin
      inst_ready_o <= ((state_reg == texture_gather_pkg::st_idle) && !(inst_take && dec.legal)) ||
                      (state_reg == texture_gather_pkg::st_result);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= inst_take && !dec.legal;
    end
  end

  // a new offset set may arrive in the same cycle as a gather that uses it: the gather sees the new set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stored_offsets_reg <= 15'h0000;
    end else if (offsets_load_i) begin
      stored_offsets_reg <= offsets_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      compare_reg     <= 1'b0;
      ref_reg         <= 32'h00000000;
      fmt_reg         <= `FMT_FLOAT32;
      func_reg        <= `CMP_NEVER;
      samp_req_kind_o <= 3'h0;
      samp_coord_o    <= 128'h0;
      samp_offsets_o  <= 15'h0000;
      samp_resource_o <= '0;
      result_gpr_o    <= '0;
    end else if (inst_take && dec.legal) begin
      compare_reg     <= dec.compare;
      ref_reg         <= src_data_i[127:96];
      fmt_reg         <= res_format_i;
      func_reg        <= cmp_func_i;
      samp_req_kind_o <= dec.kind;
      samp_coord_o    <= src_data_i;
      samp_resource_o <= inst_word0_i[`FLD_RES_LSB +: RES_BITS];
      result_gpr_o    <= inst_word1_i[`FLD_DST_LSB +: GPR_BITS];
      if (dec.stored) begin
        samp_offsets_o <= offsets_load_i ? offsets_i : stored_offsets_reg;
      end else begin
        samp_offsets_o <= inst_word2_i[`FLD_OFFSETS_MSB:`FLD_OFFSETS_LSB];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_req_valid_o <= 1'b0;
    end else if (inst_take && dec.legal) begin
      samp_req_valid_o <= 1'b1;
    end else if (samp_req_ready_i) begin
      samp_req_valid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      resp_reg <= 128'h0;
    end else if (state_reg == texture_gather_pkg::st_wait && samp_resp_valid_i) begin
      resp_reg <= samp_resp_data_i;
    end
  end

  // ----------------------------------------------------------------
  // compare and pack
  // ----------------------------------------------------------------
  logic [3:0]   pass;
  logic [127:0] packed_data;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      depth_compare_unit u_cmp (
        .ref_i   (ref_reg),
        .texel_i (resp_reg[32*gi +: 32]),
        .fmt_i   (fmt_reg),
        .func_i  (func_reg),
        .pass_o  (pass[gi])
      );
      assign packed_data[32*gi +: 32] = !compare_reg ? resp_reg[32*gi +: 32] :
                                        pass[gi] ? `FLOAT_ONE : `FLOAT_ZERO;
    end
  endgenerate

  // compare runs one cycle after capture so the unit sees a settled texel
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_valid_o <= 1'b0;
      result_data_o  <= 128'h0;
    end else begin
      result_valid_o <= (state_reg == texture_gather_pkg::st_result);
      if (state_reg == texture_gather_pkg::st_result) begin
        result_data_o <= packed_data;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hw/texture_gather_map.svh ====
// constants for the texture gather, gradient and detail-level decoder
// Functional notes
// - Opcode 21 (0x15) is the plain four-texel gather, texels packed into x,y,z,w.
// - Opcode 29 (0x1D) gathers four texels, depth-compares each, packs the results.
// - Opcode 31 (0x1F) is the comparing gather using previously stored texel offsets.
// - Opcode 23 decimal is the non-comparing gather using previously stored offsets.
// - Stored-offset gathers ignore the immediate x, y and z offset fields.
// - Compare reference is source w, converted to the resource format first.
// - NaN kept for float formats; otherwise NaN is replaced by zero.
// - A passing compare writes 1.0, a failing one writes 0.0.
// - Opcode 7 returns horizontal derivatives of the source coordinates.
// - Opcode 8 returns vertical derivatives of the source coordinates.
// - Opcode 6 returns the computed level of detail into the destination.
// - Opcode 5 returns the number of samples of the addressed resource.
`ifndef TEXTURE_GATHER_MAP_SVH
`define TEXTURE_GATHER_MAP_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OPC_SAMPLE_COUNT     5'h05
`define OPC_DETAIL_LEVEL     5'h06
`define OPC_GRAD_H           5'h07
`define OPC_GRAD_V           5'h08
`define OPC_GATHER           5'h15
`define OPC_GATHER_STORED    5'h17
`define OPC_GATHER_CMP       5'h1D
`define OPC_GATHER_CMP_STORE 5'h1F

// ----------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------
`define FLD_OPCODE_LSB   0
`define FLD_OPCODE_MSB   4
`define FLD_RES_LSB      8
`define FLD_RES_MSB      15
`define FLD_DST_LSB      0
`define FLD_DST_MSB      6
`define FLD_OFFSETS_LSB  0
`define FLD_OFFSETS_MSB  14

// ----------------------------------------------------------------
// formats, compare functions, results
// ----------------------------------------------------------------
`define FMT_FLOAT32      2'h0
`define FMT_UNORM16      2'h1
`define FMT_UNORM24      2'h2
`define CMP_NEVER        3'h0
`define CMP_LESS         3'h1
`define CMP_EQUAL        3'h2
`define CMP_LEQUAL       3'h3
`define CMP_GREATER      3'h4
`define CMP_NOTEQUAL     3'h5
`define CMP_GEQUAL       3'h6
`define CMP_ALWAYS       3'h7
`define FLOAT_ONE        32'h3F800000
`define FLOAT_ZERO       32'h00000000

`endif

// ==== hw/texture_gather_pkg.sv ====
// types for the texture gather, gradient and detail-level decoder
package texture_gather_pkg;

  typedef enum logic [2:0] {
    kind_gather,
    kind_grad_h,
    kind_grad_v,
    kind_detail_level,
    kind_sample_count
  } sampler_kind_type;

  typedef enum logic [1:0] {
    st_idle,
    st_request,
    st_wait,
    st_result
  } state_type;

endpackage

// ==== hw/depth_compare_unit.sv ====
// one texel depth comparison with reference conversion
`timescale 1ns/1ps
`default_nettype none
`include "texture_gather_map.svh"

module depth_compare_unit (
  input  wire logic [31:0] ref_i,
  input  wire logic [31:0] texel_i,
  input  wire logic [1:0]  fmt_i,
  input  wire logic [2:0]  func_i,
  output logic             pass_o
);

  // ----------------------------------------------------------------
  // float to unorm of given width, NaN and negatives go to zero
  // ----------------------------------------------------------------
  function automatic logic [31:0] to_unorm(input logic [31:0] f, input int bits);
    int   e;
    int   sh;
    logic [31:0] mx;
    logic [31:0] r;
    mx = 32'((64'h1 << bits) - 64'h1);
    e  = int'(f[30:23]) - 127;
    sh = 23 - bits - e;
    if (f[30:23] == 8'hFF && f[22:0] != 23'h0) begin
      r = 32'h0;
    end else if (f[31] || f[30:23] == 8'h00) begin
      r = 32'h0;
    end else if (e >= 0) begin
      r = mx;
    end else if (sh >= 24) begin
      r = 32'h0;
    end else if (sh < 0) begin
      r = mx;
    end else begin
      r = {8'h00, 1'b1, f[22:0]} >> sh;
    end
    return r;
  endfunction

  // order-preserving key for ieee floats
  function automatic logic [31:0] float_key(input logic [31:0] f);
    return f[31] ? ~f : {1'b1, f[30:0]};
  endfunction

  logic [31:0] ref_conv;
  logic [31:0] tex_val;
  logic        any_nan;
  logic        lt;
  logic        eq;

  always_comb begin
    any_nan = 1'b0;
    if (fmt_i == `FMT_FLOAT32) begin
      // nan survives into the compare: every ordered test fails
      any_nan  = (ref_i[30:23] == 8'hFF && ref_i[22:0] != 23'h0) ||
                 (texel_i[30:23] == 8'hFF && texel_i[22:0] != 23'h0);
      ref_conv = float_key(ref_i);
      tex_val  = float_key(texel_i);
      if ({ref_i[30:0], texel_i[30:0]} == 62'h0) begin
        tex_val = ref_conv;
      end
    end else if (fmt_i == `FMT_UNORM16) begin
      ref_conv = to_unorm(ref_i, 16);
      tex_val  = {16'h0000, texel_i[15:0]};
    end else begin
      ref_conv = to_unorm(ref_i, 24);
      tex_val  = {8'h00, texel_i[23:0]};
    end
    lt = ref_conv < tex_val;
    eq = ref_conv == tex_val;
    case (func_i)
      `CMP_NEVER:    pass_o = 1'b0;
      `CMP_LESS:     pass_o = !any_nan && lt;
      `CMP_EQUAL:    pass_o = !any_nan && eq;
      `CMP_LEQUAL:   pass_o = !any_nan && (lt || eq);
      `CMP_GREATER:  pass_o = !any_nan && !lt && !eq;
      `CMP_NOTEQUAL: pass_o = any_nan || !eq;
      `CMP_GEQUAL:   pass_o = !any_nan && !lt;
      default:       pass_o = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// ==== verification/texture_gather_gradient_decode_properties.sv ====
// assertion checker for the texture gather decoder ports
`timescale 1ns/1ps
`default_nettype none
`include "texture_gather_map.svh"
module texture_gather_gradient_decode_properties #(
  parameter int GPR_BITS = 7,
  parameter int RES_BITS = 8
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                inst_valid_i,
  input wire logic                inst_ready_o,
  input wire logic [31:0]         inst_word0_i,
  input wire logic [31:0]         inst_word1_i,
  input wire logic [31:0]         inst_word2_i,
  input wire logic [127:0]        src_data_i,
  input wire logic                offsets_load_i,
  input wire logic [14:0]         offsets_i,
  input wire logic                samp_req_valid_o,
  input wire logic                samp_req_ready_i,
  input wire logic [127:0]        samp_coord_o,
  input wire logic [14:0]         samp_offsets_o,
  input wire logic [RES_BITS-1:0] samp_resource_o,
  input wire logic                samp_resp_valid_i,
  input wire logic [127:0]        samp_resp_data_i,
  input wire logic                result_valid_o,
  input wire logic [GPR_BITS-1:0] result_gpr_o,
  input wire logic [127:0]        result_data_o,
  input wire logic                illegal_o
);
  logic [14:0]         offs_reg;
  logic [4:0]          op_reg;
  logic [GPR_BITS-1:0] gpr_reg;
  wire logic [4:0]     op = inst_word0_i[4:0];
  wire logic           take = inst_valid_i && inst_ready_o;
  wire logic           legal = op inside {`OPC_SAMPLE_COUNT, `OPC_DETAIL_LEVEL, `OPC_GRAD_H, `OPC_GRAD_V,
                                          `OPC_GATHER, `OPC_GATHER_STORED, `OPC_GATHER_CMP, `OPC_GATHER_CMP_STORE};
  wire logic           stored = op == `OPC_GATHER_STORED || op == `OPC_GATHER_CMP_STORE;
  wire logic [14:0]    offs_exp = offsets_load_i ? offsets_i : offs_reg;
  wire logic           cmp = op_reg == `OPC_GATHER_CMP || op_reg == `OPC_GATHER_CMP_STORE;
  // shadow of the offset store, so a stored-offset gather can be judged
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      offs_reg <= 15'h0000;
    end else if (offsets_load_i) begin
      offs_reg <= offsets_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (take && legal) begin
      op_reg <= op;
      gpr_reg <= inst_word1_i[GPR_BITS-1:0];
    end
  end
  // ------------------------------------------------
  // assertions
  // ------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_bad_opcode: assert property (take && !legal |=> illegal_o && inst_ready_o && !samp_req_valid_o)
    else $error("unknown opcode not dropped");
  chk_good_opcode: assert property (take && legal |=> samp_req_valid_o && !inst_ready_o && !illegal_o)
    else $error("known opcode not forwarded");
  chk_coord_copy: assert property (take && legal |=> samp_coord_o == $past(src_data_i))
    else $error("source operand not forwarded");
  chk_imm_offsets: assert property (take && legal && !stored |=> samp_offsets_o == $past(inst_word2_i[14:0]))
    else $error("immediate offsets not forwarded");
  chk_stored_offsets: assert property (take && stored |=> samp_offsets_o == $past(offs_exp))
    else $error("stored offsets not forwarded");
  chk_stall_hold: assert property (samp_req_valid_o && !samp_req_ready_i |=>
    samp_req_valid_o && $stable(samp_coord_o) && $stable(samp_offsets_o) && $stable(samp_resource_o))
    else $error("request changed while stalled");
  chk_result_delay: assert property (samp_resp_valid_i |-> ##1 !result_valid_o ##1 result_valid_o ##1 !result_valid_o)
    else $error("result pulse at wrong cycle");
  chk_result_gpr: assert property (result_valid_o |-> result_gpr_o == gpr_reg)
    else $error("result sent to wrong register");
  chk_data_pass: assert property (samp_resp_valid_i && !cmp |-> ##2 result_data_o == $past(samp_resp_data_i, 2))
    else $error("response data altered");
endmodule
bind texture_gather_gradient_decode texture_gather_gradient_decode_properties #(
  .GPR_BITS(GPR_BITS), .RES_BITS(RES_BITS)) i_texture_gather_gradient_decode_properties (.*);
`default_nettype wire

// ==== verification/sampler_model.sv ====
// behavioural sampler answering the decoder's requests, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module sampler_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  input  wire logic [127:0] texels_i,
  input  wire logic         req_valid_i,
  output logic              req_ready_o,
  output logic              resp_valid_o,
  output logic [127:0]      resp_data_o
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  // outside a response the lines show the inverse, so stale data never looks good
  assign resp_data_o = resp_valid_o ? texels_i : ~texels_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_ready_o <= 1'h0;
      resp_valid_o <= 1'h0;
      busy_reg <= 1'h0;
      wait_reg <= 4'h0;
    end else begin
      resp_valid_o <= 1'h0;
      if (req_valid_i && req_ready_o) begin
        req_ready_o <= 1'h0;
        busy_reg <= 1'h1;
        wait_reg <= slow_i ? 4'h6 : 4'h0;
      end else if (busy_reg) begin
        if (wait_reg == 4'h0) begin
          resp_valid_o <= 1'h1;
          busy_reg <= 1'h0;
        end else begin
          wait_reg <= wait_reg - 4'h1;
        end
      end else if (slow_i) begin
        wait_reg <= req_valid_i ? wait_reg + 4'h1 : 4'h0;
        req_ready_o <= req_valid_i && wait_reg == 4'h3;
      end else begin
        req_ready_o <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/texture_gather_gradient_decode_test.sv ====
// self-checking bench for the texture gather decoder
`timescale 1ns/1ps
`default_nettype none
module texture_gather_gradient_decode_test;
  logic         clk = 1'h0, rst = 1'h1, valid = 1'h0, load = 1'h0, slow = 1'h0;
  logic [31:0]  word0 = 32'h0, word1 = 32'h0, word2 = 32'h0;
  logic [127:0] src = 128'h0, texels = 128'h0;
  logic [1:0]   fmt = 2'h0;
  logic [2:0]   func = 3'h0;
  logic [14:0]  offs = 15'h0;
  logic         ready, req_valid, req_ready, resp_valid, res_valid, illegal;
  logic [2:0]   kind;
  logic [127:0] coord, resp_data, res_data;
  logic [14:0]  req_offs;
  logic [7:0]   res_id;
  logic [6:0]   gpr;
  int           miscompares = 0, comparisons = 0;
  wire logic [2:0] flags = {res_valid, req_valid, ready};
  texture_gather_gradient_decode i_texture_gather_gradient_decode (
    .clk_i(clk), .rst_i(rst), .inst_valid_i(valid), .inst_ready_o(ready), .inst_word0_i(word0),
    .inst_word1_i(word1), .inst_word2_i(word2), .inst_word3_i(32'h0), .src_data_i(src), .res_format_i(fmt),
    .cmp_func_i(func), .offsets_load_i(load), .offsets_i(offs), .samp_req_valid_o(req_valid),
    .samp_req_ready_i(req_ready), .samp_req_kind_o(kind), .samp_coord_o(coord), .samp_offsets_o(req_offs),
    .samp_resource_o(res_id), .samp_resp_valid_i(resp_valid), .samp_resp_data_i(resp_data),
    .result_valid_o(res_valid), .result_gpr_o(gpr), .result_data_o(res_data), .illegal_o(illegal));
  sampler_model i_sampler_model (.clk_i(clk), .rst_i(rst), .slow_i(slow), .texels_i(texels),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .resp_valid_o(resp_valid), .resp_data_o(resp_data));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // which: 0 ready, 1 sampler request, 2 result
  task automatic wait_for(input int which);
    for (int n = 0; n < 40; n++) begin
      if (flags[which] === 1'h1) begin
        return;
      end
      @(negedge clk);
    end
    miscompares++;
    $display("[ERR] %0t timed out", $time);
    results();
  endtask
  task automatic run(input logic [4:0] op, input logic [2:0] ekind, input logic [14:0] eoffs,
                     input logic [127:0] edata);
    wait_for(0);
    word0 = {16'h0, 8'h5A, 3'h0, op};
    word1 = {25'h0, 2'h1, op};
    valid = 1'h1;
    @(negedge clk);
    valid = 1'h0;
    wait_for(1);
    check(kind, ekind);
    check(coord, src);
    check(res_id, 8'h5A);
    check(req_offs, eoffs);
    wait_for(2);
    check(gpr, {2'h1, op});
    check(res_data, edata);
  endtask
  // positive floats order like their bit patterns
  function automatic logic [127:0] expect_cmp(input logic [31:0] r);
    logic [127:0] e;
    logic [31:0]  t;
    logic [7:0]   pass;
    for (int i = 0; i < 4; i++) begin
      t = texels[i*32 +: 32];
      pass = {1'h1, r >= t, r != t, r > t, r <= t, r == t, r < t, 1'h0};
      e[i*32 +: 32] = pass[func] ? 32'h3F800000 : 32'h0;
    end
    return e;
  endfunction
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_queries;
    logic [4:0] ops [5] = '{5'h15, 5'h07, 5'h08, 5'h06, 5'h05};
    src = {32'h40000000, 32'h3F000000, 32'hBF800000, 32'h41200000};
    texels = {32'h11223344, 32'h55667788, 32'h99AABBCC, 32'hDDEEFF00};
    word2 = 32'hFFFF7ABC;
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      for (int k = 0; k < 5; k++) begin
        run(ops[k], k[2:0], 15'h7ABC, texels);
      end
    end
    slow = 1'h0;
    $display("queries done");
  endtask
  task automatic t_compare;
    texels = {32'h40400000, 32'h3F000000, 32'h40000000, 32'h3F800000};
    for (int f = 0; f < 8; f++) begin
      func = f[2:0];
      run(5'h1D, 3'h0, 15'h7ABC, expect_cmp(32'h40000000));
    end
    offs = 15'h0555;
    load = 1'h1;
    @(negedge clk);
    load = 1'h0;
    offs = 15'h2AAA;
    run(5'h17, 3'h0, 15'h0555, texels);
    func = 3'h6;
    run(5'h1F, 3'h0, 15'h0555, expect_cmp(32'h40000000));
    $display("compares done");
  endtask
  task automatic t_nan;
    src[127:96] = 32'h7FC00000;
    func = 3'h5;
    run(5'h1D, 3'h0, 15'h7ABC, {4{32'h3F800000}});
    func = 3'h1;
    run(5'h1D, 3'h0, 15'h7ABC, 128'h0);
    fmt = 2'h1;
    func = 3'h2;
    texels = {32'h0000FFFF, 32'h0, 32'h0000FFFF, 32'h0};
    run(5'h1D, 3'h0, 15'h7ABC, {32'h0, 32'h3F800000, 32'h0, 32'h3F800000});
    // reference 0.5 becomes half scale in the resource format
    src[127:96] = 32'h3F000000;
    texels = {32'h00008000, 32'h00007FFF, 32'h00008000, 32'h00FF8000};
    run(5'h1D, 3'h0, 15'h7ABC, {32'h3F800000, 32'h0, 32'h3F800000, 32'h3F800000});
    fmt = 2'h2;
    texels = {32'h00800000, 32'h007FFFFF, 32'hFF800000, 32'h00008000};
    run(5'h1D, 3'h0, 15'h7ABC, {32'h3F800000, 32'h0, 32'h3F800000, 32'h0});
    $display("nan done");
  endtask
  task automatic t_illegal;
    wait_for(0);
    word0 = 32'h0;
    valid = 1'h1;
    @(negedge clk);
    word0 = 32'h4;
    check({illegal, ready, req_valid}, 3'h6);
    @(negedge clk);
    valid = 1'h0;
    check({illegal, ready, req_valid}, 3'h6);
    @(negedge clk);
    check({illegal, ready, req_valid}, 3'h2);
    $display("unknown opcodes done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    t_queries();
    t_compare();
    t_nan();
    t_illegal();
    results();
  end
endmodule
`default_nettype wire
